// ---- latch_bank_pkg.sv ----
package latch_bank_pkg;

  localparam int WORD_W = 32;
  localparam int SEL_W = 3;

  // Destination select codes.
  localparam logic [2:0] SEL_TX = 3'h0;
  localparam logic [2:0] SEL_RX1 = 3'h2;
  localparam logic [2:0] SEL_RX2 = 3'h3;
  localparam logic [2:0] SEL_SENSOR = 3'h6;

  // Transmit-control field positions.
  localparam int TX_FAST_BIT = 10;
  localparam int TX_OSC_BIT = 9;
  localparam int TX_SLOW_BIT = 8;
  localparam int TX_AMP_BIT = 7;
  localparam int TX_LEVEL_HI = 6;
  localparam int TX_LEVEL_LO = 3;

  // Receive-chain field positions.
  localparam int RX_GAIN_EN_BIT = 20;
  localparam int RX_GAIN_HI = 19;
  localparam int RX_GAIN_LO = 17;
  localparam int RX_DRIVE_BIT = 16;
  localparam int RX_MIXER_BIT = 15;
  localparam int RX_MIXGAIN_BIT = 14;
  localparam int RX_QOFS_HI = 13;
  localparam int RX_QOFS_LO = 9;
  localparam int RX_IOFS_HI = 8;
  localparam int RX_IOFS_LO = 4;
  localparam int RX_LNA_BIT = 3;

  // Sensor group field positions.
  localparam int SNS_EN_HI = 6;
  localparam int SNS_EN_LO = 3;
  localparam int SNS_MON_HI = 12;
  localparam int SNS_MON_LO = 10;

  // Transmit chain settings.
  typedef struct packed {
    logic fast_divider_enable;
    logic osc_enable;
    logic slow_divider_enable;
    logic amp_enable;
    logic [3:0] amp_level;
  } tx_ctrl_t;

  // Receive chain settings; offset fields carry their side bit on top.
  typedef struct packed {
    logic gain_enable;
    logic [2:0] rx_gain;
    logic drive_enable;
    logic mixer_enable;
    logic mixer_low_gain;
    logic [4:0] quad_offset;
    logic [4:0] inphase_offset;
    logic lna_enable;
  } rx_ctrl_t;

  // Sensor and monitor settings.
  typedef struct packed {
    logic [3:0] sensor_enable;
    logic [2:0] monitor_sel;
  } sensor_ctrl_t;

endpackage : latch_bank_pkg

// ---- edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser with rise detection on the settled copy.
module edge_sync #(
  // Level the pin rests at; reset loads it so that no false edge follows reset.
  parameter logic IDLE = 1'b0
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Asynchronous pin and its synchronised view.
  input wire logic pin,
  output logic level,
  output logic rise
);

  logic meta;
  logic settled;
  logic prev;

  // The first stage is read only by the second to bound metastability.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta <= IDLE;
      settled <= IDLE;
      prev <= IDLE;
    end else begin
      meta <= pin;
      settled <= meta;
      prev <= settled;
    end
  end

  // Edge found by comparing the settled copy with its previous value.
  assign level = settled;
  assign rise = settled & ~prev;

endmodule : edge_sync
`default_nettype wire

// ---- serial_control_latch_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
// Write-only three-wire control port feeding four latch groups.
module serial_control_latch_bank (
  // System clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Host serial port pins.
  input wire logic serial_data,
  input wire logic serial_clock,
  input wire logic load_strobe_n,
  // Latched settings.
  output latch_bank_pkg::tx_ctrl_t tx_control,
  output latch_bank_pkg::rx_ctrl_t rx_chain_one_control,
  output latch_bank_pkg::rx_ctrl_t rx_chain_two_control,
  output latch_bank_pkg::sensor_ctrl_t sensor_monitor_select,
  output logic [2:0] analog_monitor_out
);

  logic sclk_rise;
  logic load_rise;
  logic load_level;
  logic data_level;
  logic data_meta;
  logic [latch_bank_pkg::WORD_W-1:0] shift_word;
  logic [latch_bank_pkg::SEL_W-1:0] sel;

  // Serial clock and strobe edges found in the system clock domain.
  edge_sync u_sclk (
    .clock(clock),
    .rst(rst),
    .pin(serial_clock),
    .level(),
    .rise(sclk_rise)
  );

  // The strobe rests high, so its synchroniser resets high and reset fakes no commit.
  edge_sync #(.IDLE(1'b1)) u_load (
    .clock(clock),
    .rst(rst),
    .pin(load_strobe_n),
    .level(load_level),
    .rise(load_rise)
  );

  // Data passes the same two stages so it lines up with the clock edge found.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_meta <= 1'b0;
      data_level <= 1'b0;
    end else begin
      data_meta <= serial_data;
      data_level <= data_meta;
    end
  end

  // Shift in MSB first; shifting happens only while the strobe is low.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_word <= '0;
    end else if (sclk_rise && !load_level) begin
      shift_word <= {shift_word[latch_bank_pkg::WORD_W-2:0], data_level};
    end
  end

  // The last three bits shifted choose the destination.
  assign sel = shift_word[latch_bank_pkg::SEL_W-1:0];

  // Transmit group loads only on the rising strobe with code 000.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_control <= '0;
    end else if (load_rise && sel == latch_bank_pkg::SEL_TX) begin
      tx_control.fast_divider_enable <= shift_word[latch_bank_pkg::TX_FAST_BIT];
      tx_control.osc_enable <= shift_word[latch_bank_pkg::TX_OSC_BIT];
      tx_control.slow_divider_enable <= shift_word[latch_bank_pkg::TX_SLOW_BIT];
      tx_control.amp_enable <= shift_word[latch_bank_pkg::TX_AMP_BIT];
      // Code passes straight through, so its order is the power order.
      tx_control.amp_level <= shift_word[latch_bank_pkg::TX_LEVEL_HI:latch_bank_pkg::TX_LEVEL_LO];
    end
  end

  // Both receive chains share one layout, so one generate serves them.
  latch_bank_pkg::rx_ctrl_t rx_q [2];
  for (genvar g = 0; g < 2; g++) begin : g_rx
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        rx_q[g] <= '0;
      end else if (load_rise && sel == (g == 0 ? latch_bank_pkg::SEL_RX1 : latch_bank_pkg::SEL_RX2)) begin
        rx_q[g].gain_enable <= shift_word[latch_bank_pkg::RX_GAIN_EN_BIT];
        rx_q[g].rx_gain <= shift_word[latch_bank_pkg::RX_GAIN_HI:latch_bank_pkg::RX_GAIN_LO];
        rx_q[g].drive_enable <= shift_word[latch_bank_pkg::RX_DRIVE_BIT];
        rx_q[g].mixer_enable <= shift_word[latch_bank_pkg::RX_MIXER_BIT];
        rx_q[g].mixer_low_gain <= shift_word[latch_bank_pkg::RX_MIXGAIN_BIT];
        rx_q[g].quad_offset <= shift_word[latch_bank_pkg::RX_QOFS_HI:latch_bank_pkg::RX_QOFS_LO];
        rx_q[g].inphase_offset <= shift_word[latch_bank_pkg::RX_IOFS_HI:latch_bank_pkg::RX_IOFS_LO];
        rx_q[g].lna_enable <= shift_word[latch_bank_pkg::RX_LNA_BIT];
      end
    end
  end
  assign rx_chain_one_control = rx_q[0];
  assign rx_chain_two_control = rx_q[1];

  // Sensor group; reserved codes 001, 100, 101, 111 are dropped as no-ops.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sensor_monitor_select <= '0;
    end else if (load_rise && sel == latch_bank_pkg::SEL_SENSOR) begin
      sensor_monitor_select.sensor_enable <= shift_word[latch_bank_pkg::SNS_EN_HI:latch_bank_pkg::SNS_EN_LO];
      sensor_monitor_select.monitor_sel <= shift_word[latch_bank_pkg::SNS_MON_HI:latch_bank_pkg::SNS_MON_LO];
    end
  end

  // Monitor selection code is exposed for the analog mux.
  assign analog_monitor_out = sensor_monitor_select.monitor_sel;

  // Settings hold unless a commit edge arrives.
  property p_tx_stable;
    @(posedge clock) disable iff (rst)
      !load_rise |=> $stable(tx_control);
  endproperty
  a_tx_stable: assert property (p_tx_stable) else $error("tx changed without commit");

  property p_tx_load;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_TX |=> tx_control.amp_level == $past(shift_word[6:3])
        && tx_control.amp_enable == $past(shift_word[7]);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx load wrong");

  property p_tx_enables;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_TX |=> tx_control.fast_divider_enable == $past(shift_word[10])
        && tx_control.osc_enable == $past(shift_word[9]) && tx_control.slow_divider_enable == $past(shift_word[8]);
  endproperty
  a_tx_enables: assert property (p_tx_enables) else $error("tx enables wrong");

  property p_rx1_load;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_RX1 |=> rx_chain_one_control == $past(shift_word[20:3])
        && $stable(rx_chain_two_control);
  endproperty
  a_rx1_load: assert property (p_rx1_load) else $error("rx1 load wrong");

  property p_rx2_load;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_RX2 |=> rx_chain_two_control == $past(shift_word[20:3])
        && $stable(rx_chain_one_control);
  endproperty
  a_rx2_load: assert property (p_rx2_load) else $error("rx2 load wrong");

  property p_sensor_load;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_SENSOR |=> sensor_monitor_select.sensor_enable == $past(shift_word[6:3])
        && analog_monitor_out == $past(shift_word[12:10]);
  endproperty
  a_sensor_load: assert property (p_sensor_load) else $error("sensor load wrong");

  property p_shift;
    @(posedge clock) disable iff (rst)
      sclk_rise && !load_level |=> shift_word[0] == $past(data_level) && shift_word[31:1] == $past(shift_word[30:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");

  property p_hold_high;
    @(posedge clock) disable iff (rst)
      load_level ##1 load_level |-> $stable(shift_word);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("shifted while strobe high");

  property p_reserved;
    @(posedge clock) disable iff (rst)
      load_rise && (sel == 3'h1 || sel == 3'h4 || sel == 3'h5 || sel == 3'h7) |=>
        $stable(tx_control) && $stable(sensor_monitor_select) && $stable(rx_chain_one_control)
        && $stable(rx_chain_two_control);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code changed a group");

  // Fast divider enable follows its own bit on a transmit commit.
  property p_tx_fast;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_TX |=>
        tx_control.fast_divider_enable == $past(shift_word[latch_bank_pkg::TX_FAST_BIT]);
  endproperty
  a_tx_fast: assert property (p_tx_fast) else $error("fast divider enable wrong");

  // Oscillator enable follows its own bit on a transmit commit.
  property p_tx_osc;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_TX |=>
        tx_control.osc_enable == $past(shift_word[latch_bank_pkg::TX_OSC_BIT]);
  endproperty
  a_tx_osc: assert property (p_tx_osc) else $error("oscillator enable wrong");

  // Slow divider enable follows its own bit on a transmit commit.
  property p_tx_slow;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_TX |=>
        tx_control.slow_divider_enable == $past(shift_word[latch_bank_pkg::TX_SLOW_BIT]);
  endproperty
  a_tx_slow: assert property (p_tx_slow) else $error("slow divider enable wrong");

  // Amplifier enable follows its own bit on a transmit commit.
  property p_tx_amp;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_TX |=>
        tx_control.amp_enable == $past(shift_word[latch_bank_pkg::TX_AMP_BIT]);
  endproperty
  a_tx_amp: assert property (p_tx_amp) else $error("amplifier enable wrong");

  // The level code lands unchanged, so a larger code always means more output power.
  property p_tx_level;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_TX |=>
        tx_control.amp_level == $past(shift_word[latch_bank_pkg::TX_LEVEL_HI:latch_bank_pkg::TX_LEVEL_LO]);
  endproperty
  a_tx_level: assert property (p_tx_level) else $error("amplifier level wrong");

  // Only a transmit commit may move the transmit settings.
  property p_tx_only;
    @(posedge clock) disable iff (rst)
      !(load_rise && sel == latch_bank_pkg::SEL_TX) |=> $stable(tx_control);
  endproperty
  a_tx_only: assert property (p_tx_only) else $error("tx changed on another code");

  // Only a commit with its own code may move the first receive chain.
  property p_rx1_hold;
    @(posedge clock) disable iff (rst)
      !(load_rise && sel == latch_bank_pkg::SEL_RX1) |=> $stable(rx_chain_one_control);
  endproperty
  a_rx1_hold: assert property (p_rx1_hold) else $error("rx1 changed on another code");

  // Only a commit with its own code may move the second receive chain.
  property p_rx2_hold;
    @(posedge clock) disable iff (rst)
      !(load_rise && sel == latch_bank_pkg::SEL_RX2) |=> $stable(rx_chain_two_control);
  endproperty
  a_rx2_hold: assert property (p_rx2_hold) else $error("rx2 changed on another code");

  // Only a sensor commit may move the sensor settings.
  property p_sensor_hold;
    @(posedge clock) disable iff (rst)
      !(load_rise && sel == latch_bank_pkg::SEL_SENSOR) |=> $stable(sensor_monitor_select);
  endproperty
  a_sensor_hold: assert property (p_sensor_hold) else $error("sensor changed on another code");

  // The shifter moves only on a serial clock rise, never on the system clock alone.
  property p_shift_needs_clock;
    @(posedge clock) disable iff (rst)
      !sclk_rise |=> $stable(shift_word);
  endproperty
  a_shift_needs_clock: assert property (p_shift_needs_clock) else $error("shifted without serial clock");

  // A commit leaves the shifter alone, so the same word may be committed again.
  property p_commit_keeps_shift;
    @(posedge clock) disable iff (rst)
      load_rise |=> $stable(shift_word);
  endproperty
  a_commit_keeps_shift: assert property (p_commit_keeps_shift) else $error("commit disturbed shifter");

  // One strobe edge gives exactly one commit pulse.
  property p_commit_once;
    @(posedge clock) disable iff (rst)
      load_rise |=> !load_rise;
  endproperty
  a_commit_once: assert property (p_commit_once) else $error("commit pulse too long");

  // The monitor selection moves only one cycle after a sensor commit.
  property p_monitor_change;
    @(posedge clock) disable iff (rst)
      $changed(analog_monitor_out) |-> $past(load_rise) && $past(sel) == latch_bank_pkg::SEL_SENSOR;
  endproperty
  a_monitor_change: assert property (p_monitor_change) else $error("monitor moved without commit");

  // Gain stage enable and gain code land in the first chain at their own positions.
  property p_rx1_gain;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_RX1 |=>
        rx_chain_one_control.gain_enable == $past(shift_word[latch_bank_pkg::RX_GAIN_EN_BIT])
        && rx_chain_one_control.rx_gain == $past(shift_word[latch_bank_pkg::RX_GAIN_HI:latch_bank_pkg::RX_GAIN_LO]);
  endproperty
  a_rx1_gain: assert property (p_rx1_gain) else $error("rx1 gain wrong");

  // Drive, mixer and low-noise amplifier enables of the first chain sit at their own bits.
  property p_rx1_enables;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_RX1 |=>
        rx_chain_one_control.drive_enable == $past(shift_word[latch_bank_pkg::RX_DRIVE_BIT])
        && rx_chain_one_control.mixer_enable == $past(shift_word[latch_bank_pkg::RX_MIXER_BIT])
        && rx_chain_one_control.lna_enable == $past(shift_word[latch_bank_pkg::RX_LNA_BIT]);
  endproperty
  a_rx1_enables: assert property (p_rx1_enables) else $error("rx1 enables wrong");

  // Both offset fields of the second chain keep their side bit on top.
  property p_rx2_offsets;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_RX2 |=>
        rx_chain_two_control.quad_offset == $past(shift_word[latch_bank_pkg::RX_QOFS_HI:latch_bank_pkg::RX_QOFS_LO])
        && rx_chain_two_control.inphase_offset
          == $past(shift_word[latch_bank_pkg::RX_IOFS_HI:latch_bank_pkg::RX_IOFS_LO]);
  endproperty
  a_rx2_offsets: assert property (p_rx2_offsets) else $error("rx2 offsets wrong");

  // Sensor enables and monitor code come from their own fields of a sensor commit.
  property p_sensor_fields;
    @(posedge clock) disable iff (rst)
      load_rise && sel == latch_bank_pkg::SEL_SENSOR |=>
        sensor_monitor_select.sensor_enable == $past(shift_word[latch_bank_pkg::SNS_EN_HI:latch_bank_pkg::SNS_EN_LO])
        && sensor_monitor_select.monitor_sel
          == $past(shift_word[latch_bank_pkg::SNS_MON_HI:latch_bank_pkg::SNS_MON_LO]);
  endproperty
  a_sensor_fields: assert property (p_sensor_fields) else $error("sensor fields wrong");

endmodule : serial_control_latch_bank
`default_nettype wire

// ---- host_serial_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the three-wire control port; it only ever drives, never listens.
module host_serial_model (
  // System clock, used to pace the pins.
  input wire logic clock,
  // Serial port pins toward the device.
  output logic serial_data,
  output logic serial_clock,
  output logic load_strobe_n
);
  // Idle pins: clock parked low, strobe high, no frame pending.
  initial begin
    serial_data = 1'b0;
    serial_clock = 1'b0;
    load_strobe_n = 1'b1;
  end

  // Sends one word, MSB first, at 800 ns per bit; commit low keeps the strobe high so the bits are refused.
  task automatic send_word(input logic [31:0] w, input logic commit);
    int i;
    @(posedge clock);
    load_strobe_n <= !commit;
    repeat (4) @(posedge clock);
    for (i = 31; i >= 0; i--) begin
      serial_data <= w[i];
      repeat (4) @(posedge clock);
      serial_clock <= 1'b1;
      repeat (4) @(posedge clock);
      serial_clock <= 1'b0;
    end
    repeat (4) @(posedge clock);
    // The data line no longer holds the last bit once the frame is over.
    serial_data <= !w[0];
    load_strobe_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : send_word

  // Drops and raises the strobe with no serial clock, committing whatever the shifter holds.
  task automatic pulse_strobe();
    @(posedge clock);
    load_strobe_n <= 1'b0;
    repeat (4) @(posedge clock);
    load_strobe_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : pulse_strobe
endmodule : host_serial_model
`default_nettype wire

// ---- serial_control_latch_bank_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_control_latch_bank_tb;
  typedef struct packed {logic [31:0] word; logic [17:0] exp;} row_t;
  logic clock;
  logic rst;
  wire logic serial_data;
  wire logic serial_clock;
  wire logic load_strobe_n;
  latch_bank_pkg::tx_ctrl_t tx_control;
  latch_bank_pkg::rx_ctrl_t rx_chain_one_control;
  latch_bank_pkg::rx_ctrl_t rx_chain_two_control;
  latch_bank_pkg::sensor_ctrl_t sensor_monitor_select;
  logic [2:0] analog_monitor_out;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  int k;
  logic [7:0] e_tx = 8'h00;
  logic [17:0] e_rx1 = 18'h0_0000;
  logic [17:0] e_rx2 = 18'h0_0000;
  logic [6:0] e_sns = 7'h00;
  // Reserved codes carry only their fixed all-zero payload; their expected field is unused.
  row_t rows [0:9] = '{'{32'h0000_0408, 18'h0_0081}, '{32'h0000_03F0, 18'h0_007E},
    '{32'h0015_5552, 18'h2_AAAA}, '{32'h000A_AAAB, 18'h1_5555}, '{32'h0000_1C7E, 18'h0_007F},
    '{32'h0000_0816, 18'h0_0012}, '{32'h0000_0001, 18'h0_0000}, '{32'h0000_0004, 18'h0_0000},
    '{32'h0000_0005, 18'h0_0000}, '{32'h0000_0007, 18'h0_0000}};

  serial_control_latch_bank i_serial_control_latch_bank (.clock(clock), .rst(rst), .serial_data(serial_data),
    .serial_clock(serial_clock), .load_strobe_n(load_strobe_n), .tx_control(tx_control),
    .rx_chain_one_control(rx_chain_one_control), .rx_chain_two_control(rx_chain_two_control),
    .sensor_monitor_select(sensor_monitor_select), .analog_monitor_out(analog_monitor_out));
  host_serial_model i_host_serial_model (.clock(clock), .serial_data(serial_data),
    .serial_clock(serial_clock), .load_strobe_n(load_strobe_n));

  // System clock at 10 MHz.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Compares one group value; case equality keeps unknowns from passing.
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Every group is checked each time, so a write that lands in the wrong group shows up.
  task automatic check_all();
    cmp({10'h000, tx_control}, {10'h000, e_tx});
    cmp(rx_chain_one_control, e_rx1);
    cmp(rx_chain_two_control, e_rx2);
    cmp({11'h000, sensor_monitor_select}, {11'h000, e_sns});
    cmp({15'h0000, analog_monitor_out}, {15'h0000, e_sns[2:0]});
  endtask : check_all

  task automatic tally_and_finish();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Cycle ceiling; a full run needs about 3600 cycles.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Main sequence: table rows, then a reset in mid-run and the strobe-high frame.
  initial begin
    rst = 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check_all();
    $display("test reset_values done");
    for (k = 0; k < 10; k++) begin
      i_host_serial_model.send_word(rows[k].word, 1'b1);
      case (rows[k].word[2:0])
        3'h0: e_tx = rows[k].exp[7:0];
        3'h2: e_rx1 = rows[k].exp;
        3'h3: e_rx2 = rows[k].exp;
        3'h6: e_sns = rows[k].exp[6:0];
        default: ;
      endcase
      check_all();
      $display("test row %0d done", k);
    end
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    e_tx = 8'h00;
    e_rx1 = 18'h0_0000;
    e_rx2 = 18'h0_0000;
    e_sns = 7'h00;
    @(posedge clock);
    check_all();
    $display("test mid_reset done");
    i_host_serial_model.send_word(32'h0000_0780, 1'b0);
    check_all();
    i_host_serial_model.send_word(32'h0000_0400, 1'b1);
    e_tx = 8'h80;
    check_all();
    // A frame sent with the strobe high must leave the shifter holding the last committed word.
    i_host_serial_model.send_word(32'h0000_0780, 1'b0);
    i_host_serial_model.pulse_strobe();
    check_all();
    $display("test strobe_high done");
    tally_and_finish();
  end
endmodule : serial_control_latch_bank_tb
`default_nettype wire
